// >>> hdl/dhsrw_top.v
`timescale 1ns/100ps
`include "dhsrw_defines.vh"

// Contract
// - Power-on clear (low) resets head address register to zero.
// - Head address is three data bits, stored only on an address command.
// - Address is illegal when bit 10 is set with bit 8 or 9.
// - Illegal address is not stored; seek-check status bit 2 is set.
// - Decode buffered head bits to one head only while fault flag is clear.
// - More than one head selected raises a destructive multi-head fault.
// - Sector match sets status bit 8 until count 1088 or command drops.
// - Selected unit with read gate drives read pulses to controller.
// - One read pulse per positive and per negative zero crossing.
// - Selected unit with write gate accepts formatted write pulses.
// - In write mode each write pulse toggles complementary phase outputs.
// - Write mode needs select, write gate, no fault, read-only off.
// - Read-only switch inhibits writes, lights lamp, sets status bit 6.
// - Write enable needs write command, no read gate, settled carriage.
// - Write enable cuts read path and enables write current source; code also requires write mode for current.
// - Zone code is top three cylinder bits, 128-cylinder bands.
// - Each zone step lowers write current 3.50 mA; seven zones.
// - Missing alternating write current is a destructive fault.
// - Write current without write mode is a destructive fault.
// - Carriage motion during write mode is a non-destructive fault.
// - Read gate with write mode active is a non-destructive fault.
// - First fault latches, lights lamp, blocks others, ends writing.
// - Seek check cleared by power-on clear or clear-status command.
module dhsrw_top #(
  parameter HEAD_W = `DHSRW_HEAD_W,
  parameter NUM_HEADS = `DHSRW_NUM_HEADS,
  parameter CYL_W = `DHSRW_CYL_W,
  parameter SECT_W = `DHSRW_SECT_W,
  parameter SCNT_W = `DHSRW_SCNT_W
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire power_on_clear_n_i,
  input wire clear_status_command_i,
  input wire addr_cmd_i,
  input wire [15:0] data_bus_i,
  input wire unit_select_i,
  input wire read_gate_i,
  input wire write_gate_i,
  input wire read_cmd_i,
  input wire write_cmd_i,
  input wire [SECT_W-1:0] present_sector_i,
  input wire [SECT_W-1:0] addressed_sector_i,
  input wire sector_clock_i,
  input wire [SCNT_W-1:0] sector_count_i,
  input wire read_signal_i,
  input wire data_line_i,
  input wire read_only_switch_i,
  input wire carriage_moving_i,
  input wire [CYL_W-1:0] cylinder_i,
  input wire ac_write_current_i,
  input wire dc_write_current_i,
  input wire [NUM_HEADS-1:0] head_tap_sense_i,
  output reg [HEAD_W-1:0] head_addr_o,
  output reg [NUM_HEADS-1:0] head_energize_o,
  output reg seek_check_o,
  output reg sector_match_o,
  output reg data_line_o,
  output reg data_line_oe_n_o,
  output reg write_phase_a_o,
  output reg write_phase_b_o,
  output reg write_mode_o,
  output reg write_enable_o,
  output reg read_path_connect_o,
  output reg write_current_on_o,
  output reg write_zone_bit2_o,
  output reg write_zone_bit1_o,
  output reg write_zone_bit0_o,
  output reg read_only_lamp_o,
  output reg read_only_mode_o,
  output reg rw_fault_flag_o,
  output reg fault_lamp_o,
  output reg multi_head_fault_o,
  output reg [2:0] fault_cause_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function illegal_head;
    input [HEAD_W-1:0] h;
    begin
      illegal_head = h[2] & (h[1] | h[0]);
    end
  endfunction

  function more_than_one;
    input [NUM_HEADS-1:0] v;
    integer k;
    reg seen;
    reg multi;
    begin
      seen = 1'b0;
      multi = 1'b0;
      for (k = 0; k < NUM_HEADS; k = k + 1) begin
        multi = multi | (seen & v[k]);
        seen = seen | v[k];
      end
      more_than_one = multi;
    end
  endfunction

  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  wire clr_all = sys_rst_i | ~power_on_clear_n_i;
  wire [HEAD_W-1:0] new_head =
    data_bus_i[`DHSRW_HEAD_MSB:`DHSRW_HEAD_LSB];
  wire new_illegal = illegal_head(new_head);
  wire rw_cmd = read_cmd_i | write_cmd_i;
  wire sel_read = unit_select_i & read_gate_i;
  wire sel_write = unit_select_i & write_gate_i;
  wire wmode_d = sel_write & ~rw_fault_flag_o &
    ~read_only_switch_i;
  wire wen_d = write_cmd_i & ~read_gate_i &
    ~carriage_moving_i;

  // ----------------------------------------------------------------
  // Fault terms
  // ----------------------------------------------------------------
  // Each term but flt_multi looks at registered modes, so a mode change and the
  // fault that it causes are judged one cycle apart.
  wire flt_multi = more_than_one(head_tap_sense_i);
  wire flt_noac = write_enable_o & write_mode_o &
    ~ac_write_current_i;
  wire flt_stray = dc_write_current_i & ~write_mode_o;
  wire flt_motion = write_mode_o & carriage_moving_i;
  wire flt_rdwr = write_mode_o & read_gate_i;
  wire any_fault = flt_multi | flt_noac | flt_stray | flt_motion |
    flt_rdwr;
  // Only the first fault is taken; later ones are masked.
  wire first_fault = ~rw_fault_flag_o & any_fault;

  wire [NUM_HEADS-1:0] dec_d;
  reg [2:0] cause_d;
  reg read_sig_q;
  reg data_in_q;
  reg sector_clock_q;
  reg wphase_q;

  // ----------------------------------------------------------------
  // Head decoder
  // ----------------------------------------------------------------
  // Energize only the addressed head; a fault drops them all.
  // Addresses above the head count never reach the register.
  genvar g;
  generate
    for (g = 0; g < NUM_HEADS; g = g + 1) begin : g_dec
      assign dec_d[g] = ~rw_fault_flag_o &
        ({{(32-HEAD_W){1'b0}}, head_addr_o} == g);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault cause
  // ----------------------------------------------------------------
  // Fixed priority picks one cause when several arrive together.
  always @* begin
    cause_d = `DHSRW_FLT_NONE;
    if (flt_multi) begin
      cause_d = `DHSRW_FLT_MULTI;
    end else if (flt_noac) begin
      cause_d = `DHSRW_FLT_NOAC;
    end else if (flt_stray) begin
      cause_d = `DHSRW_FLT_STRAY;
    end else if (flt_motion) begin
      cause_d = `DHSRW_FLT_MOTION;
    end else if (flt_rdwr) begin
      cause_d = `DHSRW_FLT_RDWR;
    end
  end

  // ----------------------------------------------------------------
  // Head address and seek check
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      head_addr_o <= `DHSRW_HEAD_RST;
      seek_check_o <= 1'b0;
    end else begin
      if (addr_cmd_i && !new_illegal) begin
        head_addr_o <= new_head;
      end
      // Set beats clear so an illegal address is never lost.
      if (addr_cmd_i && new_illegal) begin
        seek_check_o <= 1'b1;
      end else if (clear_status_command_i) begin
        seek_check_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sector match
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      sector_clock_q <= 1'b0;
      sector_match_o <= 1'b0;
    end else begin
      sector_clock_q <= sector_clock_i;
      // Clear wins so a dropped command never leaves a stale match.
      if (!rw_cmd || sector_count_i == `DHSRW_SECT_END_CNT) begin
        sector_match_o <= 1'b0;
      end else if (sector_clock_i && !sector_clock_q &&
                   present_sector_i == addressed_sector_i) begin
        sector_match_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      read_sig_q <= 1'b0;
      data_line_o <= 1'b0;
      data_line_oe_n_o <= 1'b1;
    end else begin
      read_sig_q <= read_signal_i;
      // Enable lags the gate by one cycle, in step with the data.
      data_line_oe_n_o <= ~sel_read;
      // Either polarity of crossing gives one pulse.
      data_line_o <= sel_read &
        (read_signal_i ^ read_sig_q);
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      data_in_q <= 1'b0;
      wphase_q <= 1'b0;
      write_mode_o <= 1'b0;
      write_enable_o <= 1'b0;
      write_phase_a_o <= 1'b0;
      write_phase_b_o <= 1'b1;
      read_path_connect_o <= 1'b1;
      write_current_on_o <= 1'b0;
    end else begin
      data_in_q <= data_line_i;
      write_mode_o <= wmode_d;
      write_enable_o <= wen_d;
      // Pulses are counted on the rising edge of the line only.
      if (write_mode_o && sel_write && data_line_i && !data_in_q) begin
        wphase_q <= ~wphase_q;
        write_phase_a_o <= ~wphase_q;
        write_phase_b_o <= wphase_q;
      end
      read_path_connect_o <= ~wen_d;
      write_current_on_o <= wen_d & wmode_d;
    end
  end

  // ----------------------------------------------------------------
  // Write current zone
  // ----------------------------------------------------------------
  // Current step per zone is an analog sink setting, not logic here.
  // No cylinder limit is applied here, so cylinders 896 and
  // above give code seven.
  always @(posedge clk_i) begin
    if (clr_all) begin
      write_zone_bit2_o <= 1'b0;
      write_zone_bit1_o <= 1'b0;
      write_zone_bit0_o <= 1'b0;
    end else begin
      write_zone_bit2_o <= cylinder_i[CYL_W-1];
      write_zone_bit1_o <= cylinder_i[CYL_W-2];
      write_zone_bit0_o <= cylinder_i[CYL_W-3];
    end
  end

  // ----------------------------------------------------------------
  // Read-only
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      read_only_lamp_o <= 1'b0;
      read_only_mode_o <= 1'b0;
    end else begin
      read_only_lamp_o <= read_only_switch_i;
      read_only_mode_o <= read_only_switch_i;
    end
  end

  // ----------------------------------------------------------------
  // Fault latch and head drive
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      rw_fault_flag_o <= 1'b0;
      fault_lamp_o <= 1'b0;
      multi_head_fault_o <= 1'b0;
      fault_cause_o <= `DHSRW_FLT_NONE;
      head_energize_o <= {NUM_HEADS{1'b0}};
    end else begin
      // Later faults are ignored so the first cause stays visible.
      if (first_fault) begin
        rw_fault_flag_o <= 1'b1;
        fault_lamp_o <= 1'b1;
        fault_cause_o <= cause_d;
        multi_head_fault_o <= (cause_d == `DHSRW_FLT_MULTI);
      end
      // Heads drop in the same cycle as the latch, not one later.
      if (first_fault) begin
        head_energize_o <= {NUM_HEADS{1'b0}};
      end else begin
        head_energize_o <= dec_d;
      end
    end
  end

endmodule // dhsrw_top

// >>> hdl/dhsrw_defines.vh
`ifndef DHSRW_DEFINES_VH
`define DHSRW_DEFINES_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DHSRW_HEAD_W 3
`define DHSRW_NUM_HEADS 5
`define DHSRW_CYL_W 10
`define DHSRW_ZONE_W 3
`define DHSRW_SECT_W 6
`define DHSRW_SCNT_W 11

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define DHSRW_HEAD_LSB 8
`define DHSRW_HEAD_MSB 10
`define DHSRW_HEAD_RST 3'h0
`define DHSRW_MAX_HEAD 3'h4
`define DHSRW_SECT_END_CNT 11'h440
`define DHSRW_ZONE_STEP_UA 3500

// ----------------------------------------------------------------
// Fault cause codes
// ----------------------------------------------------------------
`define DHSRW_FLT_NONE 3'h0
`define DHSRW_FLT_MULTI 3'h1
`define DHSRW_FLT_NOAC 3'h2
`define DHSRW_FLT_STRAY 3'h3
`define DHSRW_FLT_MOTION 3'h4
`define DHSRW_FLT_RDWR 3'h5

`endif

// >>> tb/dhsrw_sva.sv
`timescale 1ns/100ps
module dhsrw_sva (
  input wire clk_i,
  input wire sys_rst_i,
  input wire power_on_clear_n_i,
  input wire addr_cmd_i,
  input wire [15:0] data_bus_i,
  input wire data_line_i,
  input wire read_gate_i,
  input wire unit_select_i,
  input wire write_gate_i,
  input wire [10:0] sector_count_i,
  input wire [2:0] head_addr_o,
  input wire [4:0] head_energize_o,
  input wire seek_check_o,
  input wire sector_match_o,
  input wire write_phase_a_o,
  input wire write_phase_b_o,
  input wire write_mode_o,
  input wire write_enable_o,
  input wire read_path_connect_o,
  input wire rw_fault_flag_o,
  input wire [2:0] fault_cause_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !power_on_clear_n_i);
  wire bad = data_bus_i[10] & (data_bus_i[9] | data_bus_i[8]);
  property p_load; addr_cmd_i && !bad |=>
    head_addr_o == $past(data_bus_i[10:8]); endproperty
  a_load: assert property (p_load) else $error("head not loaded");
  property p_bad; addr_cmd_i && bad |=>
    seek_check_o && $stable(head_addr_o); endproperty
  a_bad: assert property (p_bad) else $error("bad head taken");
  property p_dec; !rw_fault_flag_o ##1 !rw_fault_flag_o |->
    head_energize_o == 5'h01 << $past(head_addr_o); endproperty
  a_dec: assert property (p_dec) else $error("head decode");
  property p_ph; $rose(data_line_i) && write_mode_o && unit_select_i &&
    write_gate_i |=> write_phase_a_o
    != $past(write_phase_a_o) && write_phase_a_o != write_phase_b_o;
  endproperty
  a_ph: assert property (p_ph) else $error("phase toggle");
  property p_wen; read_gate_i |=>
    !write_enable_o && read_path_connect_o; endproperty
  a_wen: assert property (p_wen) else $error("wen");
  property p_sct; sector_count_i == 11'h440 |=> !sector_match_o;
  endproperty
  a_sct: assert property (p_sct) else $error("match end");
  property p_stk; rw_fault_flag_o |=> rw_fault_flag_o &&
    $stable(fault_cause_o) && head_energize_o == 5'h00; endproperty
  a_stk: assert property (p_stk) else $error("fault latch");
  property p_wm; rw_fault_flag_o |=> !write_mode_o; endproperty
  a_wm: assert property (p_wm) else $error("write mode");
  c_bad: cover property (addr_cmd_i && bad);
  c_sct: cover property ($rose(sector_match_o));
  c_flt: cover property ($rose(rw_fault_flag_o));
endmodule // dhsrw_sva
bind dhsrw_top dhsrw_sva dhsrw_sva_inst (.*);

// >>> tb/dhsrw_ctrl_model.sv
`timescale 1ns/100ps
module dhsrw_ctrl_model (
  input wire clk_i,
  input wire rd_line_i,
  input wire rd_oe_n_i,
  output logic cmd_o = 1'b0,
  output logic [15:0] bus_o = 16'h0000,
  output logic wr_pulse_o = 1'b0
);
  int rd_cnt = 0;
  // Pulses count only while the unit owns the shared line
  always @(posedge clk_i) if (!rd_oe_n_i && rd_line_i) rd_cnt++;
  task send_addr(input logic [2:0] h);
    @(negedge clk_i);
    cmd_o = 1'b1;
    bus_o = {5'h1F, h, 8'hFF};
    @(negedge clk_i);
    cmd_o = 1'b0;
    // Idle bus must not keep showing the head field
    bus_o = ~bus_o;
  endtask
  task send_pulses(input int n);
    repeat (n) begin
      @(negedge clk_i);
      wr_pulse_o = 1'b1;
      @(negedge clk_i);
      wr_pulse_o = 1'b0;
    end
  endtask
endmodule // dhsrw_ctrl_model

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, power_on_clear_n_i = 1'b1;
  logic clear_status_command_i = 1'b0, unit_select_i = 1'b0;
  logic read_gate_i = 1'b0, write_gate_i = 1'b0, read_cmd_i = 1'b0;
  logic write_cmd_i = 1'b0, sector_clock_i = 1'b0, read_signal_i = 1'b0;
  logic read_only_switch_i = 1'b0, carriage_moving_i = 1'b0;
  logic ac_write_current_i = 1'b1, dc_write_current_i = 1'b0;
  logic [5:0] present_sector_i = 6'h00, addressed_sector_i = 6'h00;
  logic [10:0] sector_count_i = 11'h000;
  logic [9:0] cylinder_i = 10'h000;
  logic [4:0] head_tap_sense_i = 5'h00;
  wire addr_cmd_i, data_line_i, seek_check_o, sector_match_o, data_line_o;
  wire [15:0] data_bus_i;
  wire [2:0] head_addr_o, fault_cause_o;
  wire [4:0] head_energize_o;
  wire data_line_oe_n_o, write_phase_a_o, write_phase_b_o, write_mode_o;
  wire write_enable_o, read_path_connect_o, write_current_on_o;
  wire write_zone_bit2_o, write_zone_bit1_o, write_zone_bit0_o;
  wire read_only_lamp_o, read_only_mode_o, rw_fault_flag_o, fault_lamp_o;
  wire multi_head_fault_o;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  dhsrw_top dhsrw_top_inst (.*);
  dhsrw_ctrl_model dhsrw_ctrl_model_inst (.clk_i(clk_i),
    .rd_line_i(data_line_o), .rd_oe_n_i(data_line_oe_n_o),
    .cmd_o(addr_cmd_i), .bus_o(data_bus_i), .wr_pulse_o(data_line_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 4000) begin
    error_cnt++;
    give_verdict();
  end
  task w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task give_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_addr();
    for (int h = 0; h < 8; h++) begin
      dhsrw_ctrl_model_inst.send_addr(3'(h));
      w(1);
      chk("head", (h < 5) ? 16'(h) : 16'h4, head_addr_o);
      if (h < 5) chk("energ", 16'h1 << h, head_energize_o);
      chk("seek", 16'(h > 4), seek_check_o);
      clear_status_command_i = 1'b1;
      w(1);
      clear_status_command_i = 1'b0;
      chk("seek_clr", 16'h0, seek_check_o);
    end
  endtask
  task t_sect(input logic cmd, input logic e);
    read_cmd_i = cmd;
    present_sector_i = 6'h2F;
    addressed_sector_i = 6'h2F;
    sector_clock_i = 1'b1;
    w(2);
    chk("match", 16'(e), sector_match_o);
    sector_count_i = 11'h440;
    sector_clock_i = 1'b0;
    w(2);
    chk("match_end", 16'h0, sector_match_o);
    sector_count_i = 11'h000;
  endtask
  task t_read();
    int c0;
    unit_select_i = 1'b1;
    read_gate_i = 1'b1;
    w(3);
    chk("oe_n", 16'h0, data_line_oe_n_o);
    c0 = dhsrw_ctrl_model_inst.rd_cnt;
    repeat (4) begin
      read_signal_i = ~read_signal_i;
      w(2);
    end
    w(2);
    chk("pulses", 16'h4, 16'(dhsrw_ctrl_model_inst.rd_cnt - c0));
    read_gate_i = 1'b0;
  endtask
  task t_zone();
    for (int z = 0; z < 7; z++) begin
      cylinder_i = (z == 6) ? 10'h336 : 10'(z * 128 + (z % 2) * 127);
      w(2);
      chk("zone", 16'(z), {write_zone_bit2_o, write_zone_bit1_o,
        write_zone_bit0_o});
    end
  endtask
  task t_write();
    logic a;
    write_gate_i = 1'b1;
    write_cmd_i = 1'b1;
    w(3);
    chk("wmode", 16'h1, write_mode_o);
    chk("wen", 16'h1, write_enable_o);
    chk("rpath", 16'h0, read_path_connect_o);
    chk("wcur", 16'h1, write_current_on_o);
    a = write_phase_a_o;
    dhsrw_ctrl_model_inst.send_pulses(3);
    w(2);
    chk("ph_a", {15'h0, ~a}, write_phase_a_o);
    chk("ph_b", {15'h0, a}, write_phase_b_o);
    read_only_switch_i = 1'b1;
    w(3);
    chk("ro", 16'h7, {read_only_mode_o, read_only_lamp_o,
      ~write_mode_o});
    read_only_switch_i = 1'b0;
    w(3);
  endtask
  task t_fault(input logic [4:0] tap, input logic mv, input logic rg,
      input logic noac, input logic dc, input logic [2:0] cause);
    head_tap_sense_i = tap;
    carriage_moving_i = mv;
    read_gate_i = rg;
    ac_write_current_i = ~noac;
    dc_write_current_i = dc;
    // Stray current is only a fault with write mode off
    write_gate_i = ~dc;
    w(3);
    chk("flt", 16'h3, {rw_fault_flag_o, fault_lamp_o});
    chk("cause", 16'(cause), fault_cause_o);
    chk("heads", 16'h0, head_energize_o);
    chk("multi", 16'(tap != 0), multi_head_fault_o);
    // A second cause must not overwrite the first one
    head_tap_sense_i = 5'h03;
    w(2);
    chk("later", 16'(cause), fault_cause_o);
    {head_tap_sense_i, carriage_moving_i, read_gate_i} = 7'h00;
    {ac_write_current_i, dc_write_current_i, write_gate_i} = 3'b101;
    power_on_clear_n_i = 1'b0;
    w(1);
    power_on_clear_n_i = 1'b1;
    chk("clr", 16'h0, {rw_fault_flag_o, head_addr_o});
    w(3);
  endtask
  initial begin
    w(10);
    sys_rst_i = 1'b0;
    w(1);
    chk("rst", 16'h7, {data_line_oe_n_o, read_path_connect_o,
      write_phase_b_o});
    t_addr();
    t_sect(1'b1, 1'b1);
    t_sect(1'b0, 1'b0);
    t_read();
    t_zone();
    t_write();
    t_fault(5'h03, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
    t_fault(5'h00, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4);
    t_fault(5'h00, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5);
    t_fault(5'h00, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
    t_fault(5'h00, 1'b0, 1'b0, 1'b0, 1'b1, 3'h3);
    give_verdict();
  end
endmodule // testbench
